// File: inc/vopc_consts.svh
// Offsets, field masks, field positions, reset values and byte order codes of the overlay plane configuration block
`ifndef VOPC_CONSTS_SVH
`define VOPC_CONSTS_SVH

`define VOPC_ADDR_W 20
`define VOPC_OFF_CONTROL 20'h72180
`define VOPC_OFF_LINOFF 20'h72184
`define VOPC_OFF_STRIDE 20'h72188
`define VOPC_OFF_POS 20'h7218C
`define VOPC_OFF_SURF 20'h7219C

`define VOPC_CTRL_MASK 32'h0007C404
`define VOPC_STRIDE_MASK 32'h00007FC0
`define VOPC_POS_MASK 32'h0FFF0FFF
`define VOPC_SURF_MASK 32'hFFFFF000
`define VOPC_RESET_VAL 32'h00000000

`define VOPC_BIT_STD 18
`define VOPC_BIT_ORD_HI 17
`define VOPC_BIT_ORD_LO 16
`define VOPC_BIT_ROT 15
`define VOPC_BIT_PACE 14
`define VOPC_BIT_TILED 10
`define VOPC_BIT_DKEY 2

`define VOPC_ORD_YUYV 2'h0
`define VOPC_ORD_UYVY 2'h1
`define VOPC_ORD_YVYU 2'h2
`define VOPC_ORD_VYUY 2'h3

`endif

// File: inc/vopc_pkg.sv
// Types of the overlay plane configuration block
package vopc_pkg;
    typedef struct packed {
        logic colour_standard_select;
        logic [1:0] packed_byte_order;
        logic rotate_180;
        logic burst_requests;
        logic tiled;
        logic dest_key_enable;
    } vopc_ctrl_t;

    typedef struct packed {
        logic [7:0] y1;
        logic [7:0] u;
        logic [7:0] y2;
        logic [7:0] v;
    } vopc_yuv_t;

    typedef struct packed {
        logic [11:0] y;
        logic [11:0] x;
    } vopc_pos_t;
endpackage

// File: hw/vopc_plane_config.sv
// Overlay plane configuration registers, double buffering and per-pixel helpers
`timescale 1ns/100ps
`include "vopc_consts.svh"

module vopc_plane_config (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [19:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Stride from command stream
    input wire logic cmd_stride_wr,
    input wire logic [31:0] cmd_stride_data,
    // Update points
    input wire logic vblank_start,
    input wire logic pipe_disabled,
    input wire logic plane_disabled,
    // Pixel path
    input wire logic [31:0] yuv_word,
    input wire logic [23:0] primary_pixel,
    input wire logic [23:0] overlay_pixel,
    input wire logic [23:0] key_value,
    input wire logic [23:0] key_mask,
    input wire logic [31:0] tiled_start_addr,
    // Working configuration, pixel results and arm flag
    output vopc_pkg::vopc_ctrl_t active_ctrl,
    output logic [8:0] active_stride,
    output vopc_pkg::vopc_pos_t active_pos,
    output logic [31:0] first_pixel_addr,
    output vopc_pkg::vopc_yuv_t unpacked_yuv,
    output logic [23:0] blended_pixel,
    output logic update_armed
);

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function automatic logic [31:0] field_mask(input logic [19:0] a);
        unique case (a)
            `VOPC_OFF_CONTROL: field_mask = `VOPC_CTRL_MASK;
            `VOPC_OFF_LINOFF: field_mask = 32'hFFFFFFFF;
            `VOPC_OFF_STRIDE: field_mask = `VOPC_STRIDE_MASK;
            `VOPC_OFF_POS: field_mask = `VOPC_POS_MASK;
            `VOPC_OFF_SURF: field_mask = `VOPC_SURF_MASK;
            default: field_mask = 32'h00000000;
        endcase
    endfunction

    function automatic vopc_pkg::vopc_ctrl_t to_ctrl(input logic [31:0] r);
        to_ctrl.colour_standard_select = r[`VOPC_BIT_STD];
        to_ctrl.packed_byte_order = r[`VOPC_BIT_ORD_HI:`VOPC_BIT_ORD_LO];
        to_ctrl.rotate_180 = r[`VOPC_BIT_ROT];
        to_ctrl.burst_requests = r[`VOPC_BIT_PACE];
        to_ctrl.tiled = r[`VOPC_BIT_TILED];
        to_ctrl.dest_key_enable = r[`VOPC_BIT_DKEY];
    endfunction

    // ----------------------------------------
    // First stage registers
    // ----------------------------------------
    logic [31:0] plane_control;
    logic [31:0] plane_linear_offset;
    logic [31:0] plane_line_stride;
    logic [31:0] plane_screen_position;
    logic [31:0] plane_surface_base;
    logic [31:0] next_plane_control;
    logic [31:0] next_plane_linear_offset;
    logic [31:0] next_plane_line_stride;
    logic [31:0] next_plane_screen_position;
    logic [31:0] next_plane_surface_base;
    logic [31:0] next_reg_rdata;
    logic next_update_armed;
    logic [31:0] wmask;
    logic load_point;

    always_comb begin
        wmask = field_mask(reg_addr);
        next_plane_control = plane_control;
        next_plane_linear_offset = plane_linear_offset;
        next_plane_line_stride = plane_line_stride;
        next_plane_screen_position = plane_screen_position;
        next_plane_surface_base = plane_surface_base;
        next_update_armed = update_armed;
        next_reg_rdata = reg_rdata;
        if (reg_wr) begin
            unique case (reg_addr)
                `VOPC_OFF_CONTROL: next_plane_control = reg_wdata & wmask;
                `VOPC_OFF_LINOFF: next_plane_linear_offset = reg_wdata;
                `VOPC_OFF_STRIDE: next_plane_line_stride = reg_wdata & wmask;
                `VOPC_OFF_POS: next_plane_screen_position = reg_wdata & wmask;
                `VOPC_OFF_SURF: next_plane_surface_base = reg_wdata & wmask;
                default: ;
            endcase
        end
        if (cmd_stride_wr) begin
            next_plane_line_stride = cmd_stride_data & `VOPC_STRIDE_MASK;
        end
        if (load_point) begin
            next_update_armed = 1'b0;
        end
        if (reg_wr && reg_addr == `VOPC_OFF_SURF) begin
            next_update_armed = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `VOPC_OFF_CONTROL: next_reg_rdata = plane_control;
                `VOPC_OFF_LINOFF: next_reg_rdata = plane_linear_offset;
                `VOPC_OFF_STRIDE: next_reg_rdata = plane_line_stride;
                `VOPC_OFF_POS: next_reg_rdata = plane_screen_position;
                `VOPC_OFF_SURF: next_reg_rdata = plane_surface_base;
                default: next_reg_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            plane_control <= `VOPC_RESET_VAL;
            plane_linear_offset <= `VOPC_RESET_VAL;
            plane_line_stride <= `VOPC_RESET_VAL;
            plane_screen_position <= `VOPC_RESET_VAL;
            plane_surface_base <= `VOPC_RESET_VAL;
            update_armed <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            plane_control <= next_plane_control;
            plane_linear_offset <= next_plane_linear_offset;
            plane_line_stride <= next_plane_line_stride;
            plane_screen_position <= next_plane_screen_position;
            plane_surface_base <= next_plane_surface_base;
            update_armed <= next_update_armed;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------
    // Working copies
    // ----------------------------------------
    vopc_pkg::vopc_ctrl_t next_active_ctrl;
    logic [8:0] next_active_stride;
    vopc_pkg::vopc_pos_t next_active_pos;
    logic [31:0] active_base;
    logic [31:0] active_linoff;
    logic [31:0] next_active_base;
    logic [31:0] next_active_linoff;

    assign load_point = update_armed && (vblank_start || pipe_disabled || plane_disabled);

    always_comb begin
        next_active_ctrl = active_ctrl;
        next_active_stride = active_stride;
        next_active_pos = active_pos;
        next_active_base = active_base;
        next_active_linoff = active_linoff;
        if (load_point) begin
            next_active_ctrl = to_ctrl(plane_control);
            next_active_stride = plane_line_stride[14:6];
            next_active_pos.y = plane_screen_position[27:16];
            next_active_pos.x = plane_screen_position[11:0];
            next_active_base = plane_surface_base;
            next_active_linoff = plane_linear_offset;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            active_ctrl <= '0;
            active_stride <= 9'h000;
            active_pos <= '0;
            active_base <= 32'h00000000;
            active_linoff <= 32'h00000000;
        end else begin
            active_ctrl <= next_active_ctrl;
            active_stride <= next_active_stride;
            active_pos <= next_active_pos;
            active_base <= next_active_base;
            active_linoff <= next_active_linoff;
        end
    end

    // ----------------------------------------
    // Pixel helpers
    // ----------------------------------------
    vopc_pkg::vopc_yuv_t next_unpacked_yuv;
    logic [23:0] next_blended_pixel;
    logic [31:0] next_first_pixel_addr;
    logic key_hit;

    always_comb begin
        unique case (active_ctrl.packed_byte_order)
            `VOPC_ORD_YUYV: next_unpacked_yuv = {yuv_word[7:0], yuv_word[15:8], yuv_word[23:16], yuv_word[31:24]};
            `VOPC_ORD_UYVY: next_unpacked_yuv = {yuv_word[15:8], yuv_word[7:0], yuv_word[31:24], yuv_word[23:16]};
            `VOPC_ORD_YVYU: next_unpacked_yuv = {yuv_word[7:0], yuv_word[31:24], yuv_word[23:16], yuv_word[15:8]};
            `VOPC_ORD_VYUY: next_unpacked_yuv = {yuv_word[15:8], yuv_word[23:16], yuv_word[31:24], yuv_word[7:0]};
        endcase
        key_hit = ((primary_pixel ^ key_value) & key_mask) == 24'h000000;
        next_blended_pixel = (active_ctrl.dest_key_enable && key_hit) ? overlay_pixel : primary_pixel;
        // Tiled base reinterpreted as start of tiled panning address
        next_first_pixel_addr = active_ctrl.tiled ? tiled_start_addr : active_base + active_linoff;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            unpacked_yuv <= '0;
            blended_pixel <= 24'h000000;
            first_pixel_addr <= 32'h00000000;
        end else begin
            unpacked_yuv <= next_unpacked_yuv;
            blended_pixel <= next_blended_pixel;
            first_pixel_addr <= next_first_pixel_addr;
        end
    end
    // Standard, rotation and pacing leave via active_ctrl to the converter and fetcher

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_arm_on_surf: assert property (reg_wr && reg_addr == `VOPC_OFF_SURF |=> update_armed) else $error("arm missing");
    a_no_load_unarmed: assert property (!update_armed |=> $stable(active_stride) && $stable(active_pos)) else $error("unarmed load");
    a_load_stride: assert property (load_point |=> active_stride == $past(plane_line_stride[14:6])) else $error("stride load");
    a_pos_fields: assert property (load_point |=> active_pos.y == $past(plane_screen_position[27:16]) && active_pos.x == $past(plane_screen_position[11:0])) else $error("pos load");
    a_rsvd_zero: assert property ((plane_line_stride & ~`VOPC_STRIDE_MASK) == 32'h0 && (plane_screen_position & ~`VOPC_POS_MASK) == 32'h0) else $error("reserved set");
    a_read_first: assert property (reg_rd && reg_addr == `VOPC_OFF_POS |=> reg_rdata == $past(plane_screen_position)) else $error("readback");
    a_key_pass: assert property (!active_ctrl.dest_key_enable |=> blended_pixel == $past(primary_pixel)) else $error("key pass");
    a_yuyv_lanes: assert property (active_ctrl.packed_byte_order == `VOPC_ORD_YUYV |=> unpacked_yuv.y1 == $past(yuv_word[7:0]) && unpacked_yuv.v == $past(yuv_word[31:24])) else $error("lanes");
    a_linear_addr: assert property (!active_ctrl.tiled |=> first_pixel_addr == $past(active_base + active_linoff)) else $error("addr");
    a_tiled_addr: assert property (active_ctrl.tiled |=> first_pixel_addr == $past(tiled_start_addr)) else $error("tiled addr");
    a_cmd_stride: assert property (cmd_stride_wr |=> plane_line_stride == $past(cmd_stride_data & `VOPC_STRIDE_MASK)) else $error("cmd stride");

    c_arm_then_load: cover property (update_armed ##[1:20] load_point);
    c_key_hit: cover property (active_ctrl.dest_key_enable && key_hit);
    c_tiled: cover property (active_ctrl.tiled);
    c_rotated: cover property (active_ctrl.rotate_180);

endmodule

// File: verif/tb_video_overlay_plane_config.sv
// Self-checking bench for the overlay plane configuration block
`timescale 1ns/100ps
`include "vopc_consts.svh"

module tb_video_overlay_plane_config;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [19:0] reg_addr = 20'h00000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata;
    logic cmd_stride_wr = 1'b0;
    logic [31:0] cmd_stride_data = 32'h00000000;
    logic vblank_start = 1'b0;
    logic pipe_disabled = 1'b0;
    logic plane_disabled = 1'b0;
    logic [31:0] yuv_word = 32'h44332211;
    logic [23:0] primary_pixel = 24'h123456;
    logic [23:0] overlay_pixel = 24'hABCDEF;
    logic [23:0] key_value = 24'h12345F;
    logic [23:0] key_mask = 24'hFFFFF0;
    logic [31:0] tiled_start_addr = 32'h00ABC000;
    vopc_pkg::vopc_ctrl_t active_ctrl;
    logic [8:0] active_stride;
    vopc_pkg::vopc_pos_t active_pos;
    logic [31:0] first_pixel_addr;
    vopc_pkg::vopc_yuv_t unpacked_yuv;
    logic [23:0] blended_pixel;
    logic update_armed;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] rd_val;
    logic [31:0] yuv_exp [4] = '{32'h11223344, 32'h22114433, 32'h11443322, 32'h22334411};

    vopc_plane_config i_vopc_plane_config (
        .mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_stride_wr(cmd_stride_wr),
        .cmd_stride_data(cmd_stride_data), .vblank_start(vblank_start), .pipe_disabled(pipe_disabled),
        .plane_disabled(plane_disabled), .yuv_word(yuv_word), .primary_pixel(primary_pixel),
        .overlay_pixel(overlay_pixel), .key_value(key_value), .key_mask(key_mask),
        .tiled_start_addr(tiled_start_addr), .active_ctrl(active_ctrl), .active_stride(active_stride),
        .active_pos(active_pos), .first_pixel_addr(first_pixel_addr), .unpacked_yuv(unpacked_yuv),
        .blended_pixel(blended_pixel), .update_armed(update_armed)
    );

    // ----------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------
    initial begin
        forever #10 mclk = ~mclk;
    end

    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [19:0] a);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
    endtask

    // Arm through the surface write, then pulse one update point
    task automatic arm_load(input int how);
        wr(`VOPC_OFF_SURF, 32'h10000ABC);
        chk({31'h0, update_armed}, 32'h1, "armed");
        vblank_start = (how == 0);
        pipe_disabled = (how == 1);
        plane_disabled = (how == 2);
        @(negedge mclk);
        {vblank_start, pipe_disabled, plane_disabled} = 3'h0;
        chk({31'h0, update_armed}, 32'h0, "disarm");
        @(negedge mclk);
    endtask

    task automatic final_report();
        $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(`VOPC_OFF_CONTROL);
        chk(rd_val, 32'h0, "ctrl reset");
        rd(`VOPC_OFF_STRIDE);
        chk(rd_val, 32'h0, "stride reset");
        chk({23'h0, active_stride}, 32'h0, "active stride reset");
        $display("test reset done");
    endtask

    task automatic t_mask_and_load();
        wr(`VOPC_OFF_CONTROL, 32'hFFBFFFFF);
        wr(`VOPC_OFF_LINOFF, 32'hFFFFFFFC);
        wr(`VOPC_OFF_STRIDE, 32'hFFFF8E3F);
        wr(`VOPC_OFF_POS, 32'hFFFFFFFF);
        rd(`VOPC_OFF_CONTROL);
        chk(rd_val, 32'h0007C404, "ctrl mask");
        rd(`VOPC_OFF_LINOFF);
        chk(rd_val, 32'hFFFFFFFC, "linoff");
        rd(`VOPC_OFF_STRIDE);
        chk(rd_val, 32'h00000E00, "stride mask");
        rd(`VOPC_OFF_POS);
        chk(rd_val, 32'h0FFF0FFF, "pos mask");
        rd(20'h721A8);
        chk(rd_val, 32'h0, "unmapped");
        vblank_start = 1'b1;
        @(negedge mclk);
        vblank_start = 1'b0;
        @(negedge mclk);
        chk({23'h0, active_stride}, 32'h0, "unarmed load");
        arm_load(0);
        chk({23'h0, active_stride}, 32'h00000038, "stride load");
        chk({8'h0, active_pos}, 32'h00FFFFFF, "pos load");
        chk({25'h0, active_ctrl}, 32'h0000007F, "ctrl load");
        @(negedge mclk);
        chk(first_pixel_addr, 32'h00ABC000, "tiled addr");
        $display("test mask and load done");
    endtask

    task automatic t_stride_sources();
        wr(`VOPC_OFF_STRIDE, 32'h00000400);
        rd(`VOPC_OFF_STRIDE);
        chk(rd_val, 32'h00000400, "first stage");
        chk({23'h0, active_stride}, 32'h00000038, "working held");
        @(negedge mclk);
        cmd_stride_wr = 1'b1;
        cmd_stride_data = 32'hFFFF0200;
        @(negedge mclk);
        cmd_stride_wr = 1'b0;
        rd(`VOPC_OFF_STRIDE);
        chk(rd_val, 32'h00000200, "cmd stride");
        wr(`VOPC_OFF_POS, 32'h01230456);
        arm_load(1);
        chk({23'h0, active_stride}, 32'h00000008, "cmd stride load");
        chk({8'h0, active_pos}, 32'h00123456, "pos fields");
        $display("test stride sources done");
    endtask

    task automatic t_orders_and_key();
        wr(`VOPC_OFF_LINOFF, 32'h00001234);
        for (int o = 0; o < 4; o++) begin
            wr(`VOPC_OFF_CONTROL, {14'h0, o[1:0], 16'h0004});
            arm_load(2);
            chk({25'h0, active_ctrl}, {25'h0, 1'b0, o[1:0], 4'h1}, "order ctrl");
            @(negedge mclk);
            chk(unpacked_yuv, yuv_exp[o], "unpack");
        end
        chk(first_pixel_addr, 32'h10001234, "linear addr");
        chk({8'h0, blended_pixel}, 32'h00ABCDEF, "key match");
        primary_pixel = 24'h123556;
        @(negedge mclk);
        @(negedge mclk);
        chk({8'h0, blended_pixel}, 32'h00123556, "key miss");
        wr(`VOPC_OFF_CONTROL, 32'h00000000);
        arm_load(0);
        primary_pixel = 24'h123456;
        @(negedge mclk);
        @(negedge mclk);
        chk({8'h0, blended_pixel}, 32'h00123456, "key off");
        $display("test orders and key done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_mask_and_load();
        t_stride_sources();
        t_orders_and_key();
        final_report();
    end
endmodule
